/* include/bsp_pkg.sv */
// package: pin function codes, strap status layout and register map
`default_nettype none
package bsp_pkg;
  typedef enum logic [1:0] {
    BSP_FN_CLKRUN  = 2'h0,
    BSP_FN_LOCK    = 2'h1,
    BSP_FN_HOTSWAP = 2'h3
  } bsp_fn_t;

  localparam int          BSP_NUM_REQ     = 4;
  localparam int          BSP_AXI_AW      = 4;
  localparam int          BSP_WORD_LSB    = 2;
  localparam logic [3:0]  BSP_OFS_CTRL    = 4'h0;
  localparam logic [3:0]  BSP_OFS_STATUS  = 4'h4;
  localparam logic [1:0]  BSP_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  BSP_RESP_SLVERR = 2'h2;

  localparam int          BSP_CTRL_GROUP_LSB = 0;
  localparam int          BSP_CTRL_LED_BIT   = 8;
  localparam int          BSP_LANE_GROUP     = 0;
  localparam int          BSP_LANE_LED       = 1;
  localparam logic        BSP_LED_RESET      = 1'b0;

  localparam int          BSP_ST_FST   = 0;
  localparam int          BSP_ST_SND   = 1;
  localparam int          BSP_ST_EXT   = 2;
  localparam int          BSP_ST_SCAN  = 3;
  localparam int          BSP_ST_DONE  = 4;
  localparam int          BSP_ST_PARK  = 5;
  localparam int          BSP_ST_SPIN  = 6;
  localparam int          BSP_ST_FN    = 8;
  localparam int          BSP_ST_GNT   = 16;
endpackage
`default_nettype wire

/* hdl/bsp_arbiter.sv */
// two-group rotating arbiter for the downstream bus
`timescale 1ns/1ps
`default_nettype none
module bsp_arbiter #(
  parameter int N = 5
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  input  wire logic         enable,
  input  wire logic         bus_idle,
  input  wire logic [N-1:0] req,
  input  wire logic [N-1:0] high_group,
  output logic      [N-1:0] grant
);
  localparam int IW = (N > 1) ? $clog2(N) : 1;

  logic [N-1:0]  grant_q;
  logic [IW-1:0] hi_last_q;
  logic [IW-1:0] lo_last_q;
  logic [N-1:0]  hi_pick;
  logic [N-1:0]  lo_pick;

  function automatic logic [N-1:0] rr_pick(input logic [N-1:0] r, input logic [IW-1:0] last);
    logic [N-1:0] p;
    int           k;
    p = '0;
    for (int i = N; i >= 1; i--) begin
      k = (int'(last) + i) % N;
      if (r[k]) begin
        p    = '0;
        p[k] = 1'b1;
      end
    end
    return p;
  endfunction

  function automatic logic [IW-1:0] oh_index(input logic [N-1:0] oh);
    logic [IW-1:0] ix;
    ix = '0;
    for (int i = 0; i < N; i++) begin
      if (oh[i]) ix = IW'(i);
    end
    return ix;
  endfunction

  assign hi_pick = rr_pick(req & high_group, hi_last_q);
  assign lo_pick = rr_pick(req & ~high_group, lo_last_q);
  assign grant   = grant_q;

  // high group first, each group rotates; parks on last owner when idle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      grant_q   <= '0;
      hi_last_q <= '0;
      lo_last_q <= '0;
    end else if (ce) begin
      if (!enable) begin
        grant_q <= '0;
      end else if (bus_idle && |req) begin
        if (|(req & high_group)) begin
          grant_q   <= hi_pick;
          hi_last_q <= oh_index(hi_pick);
        end else begin
          grant_q   <= lo_pick;
          lo_last_q <= oh_index(lo_pick);
        end
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_grant_single_owner: assert property ($onehot0(grant_q))
    else $error("more than one grant active");
  a_high_group_first: assert property (ce && enable && bus_idle && |(req & high_group)
    |=> |(grant_q & $past(high_group)))
    else $error("low group granted over high group");
  a_disabled_no_grant: assert property (ce && !enable |=> grant_q == '0)
    else $error("grant held while arbiter disabled");
endmodule
`default_nettype wire

/* hdl/bsp_strap_pinmux.sv */
// strap latch, multifunction pin steering, grant pins and register slave
//
// Behaviour
// - shared input is second mode strap when first is low, else power clock control
// - upstream terminal is clock-run, lock or enumeration, chosen by mode straps
// - downstream terminal is clock-run, lock or handle switch, chosen by mode straps
// - arbiter strap low: internal arbiter on, device drives all grant pins
// - arbiter strap high: internal arbiter off, an external arbiter grants the bus
// - external mode: request pin 0 is own grant, grant pin 0 own request
// - external mode: parked when grant seen, bus idle and nothing pending
// - scan strap low drives scan signal, high drives hot-swap indicator
// - four active-low requests, each in high or low rotating group
// - at most one active-low grant at a time, start once bus idle
`timescale 1ns/1ps
`default_nettype none
module bsp_strap_pinmux #(
  parameter int               N_REQ  = bsp_pkg::BSP_NUM_REQ,
  parameter bsp_pkg::bsp_fn_t MAP_00 = bsp_pkg::BSP_FN_CLKRUN,
  parameter bsp_pkg::bsp_fn_t MAP_01 = bsp_pkg::BSP_FN_LOCK,
  parameter bsp_pkg::bsp_fn_t MAP_1X = bsp_pkg::BSP_FN_HOTSWAP
) (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic                          ce,
  input  wire logic                          mode_strap_first,
  input  wire logic                          mode_strap_second,
  input  wire logic                          arbiter_select_strap_n,
  input  wire logic                          scan_test_mode_n,
  output logic                               bus_power_clock_control,
  input  wire logic                          upstream_multifunction_pin_i,
  output logic                               upstream_multifunction_pin_o,
  output logic                               upstream_multifunction_pin_oe_n,
  input  wire logic                          downstream_multifunction_pin_i,
  output logic                               downstream_multifunction_pin_o,
  output logic                               downstream_multifunction_pin_oe_n,
  input  wire logic                          up_clock_run_drive,
  input  wire logic                          hot_swap_enumeration_drive,
  input  wire logic                          dn_clock_run_drive,
  input  wire logic                          dn_lock_drive,
  output logic                               upstream_clock_run_n,
  output logic                               upstream_lock_n,
  output logic                               downstream_clock_run_n,
  output logic                               downstream_lock_n,
  output logic                               hot_swap_handle_switch_n,
  input  wire logic [N_REQ-1:0]              req_pin_n_i,
  output logic      [N_REQ-1:0]              gnt_pin_n_o,
  output logic      [N_REQ-1:0]              gnt_pin_oe_n,
  input  wire logic                          core_req,
  input  wire logic                          bus_idle,
  output logic                               core_grant,
  output logic                               bus_parked,
  input  wire logic                          scan_enable,
  input  wire logic                          scan_indicator_pin_i,
  output logic                               scan_indicator_pin_o,
  output logic                               scan_indicator_pin_oe_n,
  input  wire logic [bsp_pkg::BSP_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [bsp_pkg::BSP_AXI_AW-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready
);
  localparam int NA = N_REQ + 1;
  localparam int AW = bsp_pkg::BSP_AXI_AW;
  localparam int WL = bsp_pkg::BSP_WORD_LSB;

  logic             strap_done_q, first_q, second_q, arb_ext_q, scan_tm_n_q;
  logic             pwr_clk_q;
  bsp_pkg::bsp_fn_t fn_sel;
  logic             up_oe_n_q, dn_oe_n_q;
  logic             up_clkrun_q, up_lock_q, dn_clkrun_q, dn_lock_q, hs_switch_q;
  logic [N_REQ-1:0] gnt_o_q, gnt_oe_n_q;
  logic             core_grant_q, parked_q;
  logic             scan_o_q, scan_oe_n_q;
  logic [NA-1:0]    group_q;
  logic             led_q;
  logic [NA-1:0]    arb_grant;
  logic             aw_got_q, w_got_q, bvalid_q, rvalid_q;
  logic [AW-1:0]    awaddr_q;
  logic [31:0]      wdata_q, rdata_q;
  logic [3:0]       wstrb_q;
  logic [1:0]       bresp_q, rresp_q;
  logic [31:0]      ctrl_word, status_word;
  logic             wr_fire, wr_ctrl, wr_mapped;

  // straps caught once at the first enabled edge after reset release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_done_q <= 1'b0;
      first_q      <= 1'b0;
      second_q     <= 1'b0;
      arb_ext_q    <= 1'b0;
      scan_tm_n_q  <= 1'b1;
    end else if (ce && !strap_done_q) begin
      strap_done_q <= 1'b1;
      first_q      <= mode_strap_first;
      second_q     <= mode_strap_second & ~mode_strap_first;
      arb_ext_q    <= arbiter_select_strap_n;
      scan_tm_n_q  <= scan_test_mode_n;
    end
  end

  assign fn_sel = first_q ? MAP_1X : (second_q ? MAP_01 : MAP_00);

  // shared input follows as power clock control only in that mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_clk_q <= 1'b0;
    end else if (ce) begin
      pwr_clk_q <= strap_done_q & first_q & mode_strap_second;
    end
  end
  assign bus_power_clock_control = pwr_clk_q;

  // multifunction terminals: open-drain low drive, inputs gated by function
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      up_oe_n_q   <= 1'b1;
      dn_oe_n_q   <= 1'b1;
      up_clkrun_q <= 1'b1;
      up_lock_q   <= 1'b1;
      dn_clkrun_q <= 1'b1;
      dn_lock_q   <= 1'b1;
      hs_switch_q <= 1'b1;
    end else if (ce) begin
      up_oe_n_q   <= ~(strap_done_q && ((fn_sel == bsp_pkg::BSP_FN_CLKRUN && up_clock_run_drive) ||
                     (fn_sel == bsp_pkg::BSP_FN_HOTSWAP && hot_swap_enumeration_drive)));
      dn_oe_n_q   <= ~(strap_done_q && ((fn_sel == bsp_pkg::BSP_FN_CLKRUN && dn_clock_run_drive) ||
                     (fn_sel == bsp_pkg::BSP_FN_LOCK && dn_lock_drive)));
      up_clkrun_q <= !(strap_done_q && fn_sel == bsp_pkg::BSP_FN_CLKRUN) || upstream_multifunction_pin_i;
      up_lock_q   <= !(strap_done_q && fn_sel == bsp_pkg::BSP_FN_LOCK) || upstream_multifunction_pin_i;
      dn_clkrun_q <= !(strap_done_q && fn_sel == bsp_pkg::BSP_FN_CLKRUN) || downstream_multifunction_pin_i;
      dn_lock_q   <= !(strap_done_q && fn_sel == bsp_pkg::BSP_FN_LOCK) || downstream_multifunction_pin_i;
      hs_switch_q <= !(strap_done_q && fn_sel == bsp_pkg::BSP_FN_HOTSWAP) || downstream_multifunction_pin_i;
    end
  end
  assign upstream_multifunction_pin_o      = 1'b0;
  assign downstream_multifunction_pin_o    = 1'b0;
  assign upstream_multifunction_pin_oe_n   = up_oe_n_q;
  assign downstream_multifunction_pin_oe_n = dn_oe_n_q;
  assign upstream_clock_run_n              = up_clkrun_q;
  assign upstream_lock_n                   = up_lock_q;
  assign downstream_clock_run_n            = dn_clkrun_q;
  assign downstream_lock_n                 = dn_lock_q;
  assign hot_swap_handle_switch_n          = hs_switch_q;

  // internal arbiter: pin requests plus the device's own request on top
  bsp_arbiter #(.N(NA)) u_arb (
    .clk        (clk),
    .rst_b      (rst_b),
    .ce         (ce),
    .enable     (strap_done_q & ~arb_ext_q),
    .bus_idle   (bus_idle),
    .req        ({core_req, ~req_pin_n_i}),
    .high_group (group_q),
    .grant      (arb_grant)
  );

  // grant pins, own grant and parking
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gnt_o_q      <= '1;
      gnt_oe_n_q   <= '1;
      core_grant_q <= 1'b0;
      parked_q     <= 1'b0;
    end else if (ce) begin
      if (!strap_done_q) begin
        gnt_o_q      <= '1;
        gnt_oe_n_q   <= '1;
        core_grant_q <= 1'b0;
        parked_q     <= 1'b0;
      end else if (arb_ext_q) begin
        gnt_oe_n_q   <= {{(N_REQ-1){1'b1}}, 1'b0};
        gnt_o_q      <= {{(N_REQ-1){1'b1}}, ~core_req};
        core_grant_q <= ~req_pin_n_i[0];
        parked_q     <= ~req_pin_n_i[0] & bus_idle & ~core_req;
      end else begin
        gnt_oe_n_q   <= '0;
        gnt_o_q      <= ~arb_grant[N_REQ-1:0];
        core_grant_q <= arb_grant[N_REQ];
        parked_q     <= arb_grant[N_REQ] & bus_idle & ~core_req;
      end
    end
  end
  assign gnt_pin_n_o  = gnt_o_q;
  assign gnt_pin_oe_n = gnt_oe_n_q;
  assign core_grant   = core_grant_q;
  assign bus_parked   = parked_q;

  // scan / indicator shared pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scan_o_q    <= 1'b0;
      scan_oe_n_q <= 1'b1;
    end else if (ce) begin
      scan_o_q    <= scan_tm_n_q ? led_q : scan_enable;
      scan_oe_n_q <= ~strap_done_q;
    end
  end
  assign scan_indicator_pin_o    = scan_o_q;
  assign scan_indicator_pin_oe_n = scan_oe_n_q;

  // register bus: write side
  assign s_axi_awready = ce & ~aw_got_q & ~bvalid_q;
  assign s_axi_wready  = ce & ~w_got_q & ~bvalid_q;
  assign wr_fire       = aw_got_q & w_got_q;
  assign wr_ctrl       = awaddr_q[AW-1:WL] == bsp_pkg::BSP_OFS_CTRL[AW-1:WL];
  assign wr_mapped     = wr_ctrl | (awaddr_q[AW-1:WL] == bsp_pkg::BSP_OFS_STATUS[AW-1:WL]);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
      bvalid_q <= 1'b0;
      bresp_q  <= bsp_pkg::BSP_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_mapped ? bsp_pkg::BSP_RESP_OKAY : bsp_pkg::BSP_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // control register: priority groups and indicator
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      group_q <= '0;
      led_q   <= bsp_pkg::BSP_LED_RESET;
    end else if (ce && wr_fire && wr_ctrl) begin
      if (wstrb_q[bsp_pkg::BSP_LANE_GROUP]) group_q <= wdata_q[bsp_pkg::BSP_CTRL_GROUP_LSB +: NA];
      if (wstrb_q[bsp_pkg::BSP_LANE_LED]) led_q <= wdata_q[bsp_pkg::BSP_CTRL_LED_BIT];
    end
  end

  always_comb begin
    ctrl_word = '0;
    ctrl_word[bsp_pkg::BSP_CTRL_GROUP_LSB +: NA] = group_q;
    ctrl_word[bsp_pkg::BSP_CTRL_LED_BIT]         = led_q;
    status_word = '0;
    status_word[bsp_pkg::BSP_ST_FST]     = first_q;
    status_word[bsp_pkg::BSP_ST_SND]     = second_q;
    status_word[bsp_pkg::BSP_ST_EXT]     = arb_ext_q;
    status_word[bsp_pkg::BSP_ST_SCAN]    = scan_tm_n_q;
    status_word[bsp_pkg::BSP_ST_DONE]    = strap_done_q;
    status_word[bsp_pkg::BSP_ST_PARK]    = parked_q;
    status_word[bsp_pkg::BSP_ST_SPIN]    = scan_indicator_pin_i;
    status_word[bsp_pkg::BSP_ST_FN +: 2] = fn_sel;
    status_word[bsp_pkg::BSP_ST_GNT +: NA] = {core_grant_q, ~gnt_o_q & ~gnt_oe_n_q};
  end

  // register bus: read side
  assign s_axi_arready = ce & ~rvalid_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= bsp_pkg::BSP_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rresp_q  <= bsp_pkg::BSP_RESP_OKAY;
        if (s_axi_araddr[AW-1:WL] == bsp_pkg::BSP_OFS_CTRL[AW-1:WL]) begin
          rdata_q <= ctrl_word;
        end else if (s_axi_araddr[AW-1:WL] == bsp_pkg::BSP_OFS_STATUS[AW-1:WL]) begin
          rdata_q <= status_word;
        end else begin
          rdata_q <= '0;
          rresp_q <= bsp_pkg::BSP_RESP_SLVERR;
        end
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_pwr_clk_follow: assert property (ce && strap_done_q |=>
    bus_power_clock_control == $past(first_q && mode_strap_second))
    else $error("power clock control not gated by first strap");
  a_straps_held: assert property (strap_done_q |=> strap_done_q &&
    $stable({first_q, second_q, arb_ext_q, scan_tm_n_q}))
    else $error("strap value changed in operation");
  a_up_lock_input: assert property (ce && strap_done_q && fn_sel == bsp_pkg::BSP_FN_LOCK
    |=> upstream_multifunction_pin_oe_n && upstream_lock_n == $past(upstream_multifunction_pin_i))
    else $error("upstream terminal not acting as lock input");
  a_dn_clkrun_drive: assert property (ce && strap_done_q && fn_sel == bsp_pkg::BSP_FN_CLKRUN
    && dn_clock_run_drive |=> !downstream_multifunction_pin_oe_n)
    else $error("downstream clock-run not driven");
  a_int_grant_drive: assert property (ce && strap_done_q && !arb_ext_q |=> gnt_pin_oe_n == '0)
    else $error("grant pins not driven in internal mode");
  a_ext_grant_free: assert property (ce && strap_done_q && arb_ext_q
    |=> gnt_pin_oe_n[N_REQ-1:1] == '1 ##1 gnt_pin_oe_n[N_REQ-1:1] == '1)
    else $error("grant pins driven in external mode");
  a_ext_req_pin: assert property (ce && strap_done_q && arb_ext_q |=>
    gnt_pin_n_o[0] == !$past(core_req) && core_grant == !$past(req_pin_n_i[0]))
    else $error("pin 0 not repurposed in external mode");
  a_ext_park: assert property (ce && strap_done_q && arb_ext_q |=>
    bus_parked == $past(!req_pin_n_i[0] && bus_idle && !core_req))
    else $error("parking state wrong");
  a_scan_route: assert property (ce && strap_done_q |=>
    scan_indicator_pin_o == $past(scan_tm_n_q ? led_q : scan_enable) && !scan_indicator_pin_oe_n)
    else $error("scan pin routed wrong");
  a_unsel_idle: assert property (ce && fn_sel != bsp_pkg::BSP_FN_CLKRUN
    |=> upstream_clock_run_n && downstream_clock_run_n)
    else $error("unselected clock-run seen active");
  a_pin_grant_single: assert property ($onehot0(~gnt_pin_n_o & ~gnt_pin_oe_n))
    else $error("two grant pins active");
endmodule
`default_nettype wire

/* testbench/bsp_bus_partner.sv */
// partner model: downstream initiators and external arbiter
`timescale 1ns/1ps
`default_nettype none
module bsp_bus_partner (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ext_mode,
  input  wire logic       park,
  input  wire logic [3:0] lag,
  input  wire logic [3:0] init_req_n,
  input  wire logic [3:0] gnt_pin_n_o,
  input  wire logic [3:0] gnt_pin_oe_n,
  output logic      [3:0] req_pin_n
);
  logic       grant_q;
  logic [3:0] wait_q;
  // grants the device's request lag+1 cycles after seeing it, else parks on it while park is high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      grant_q <= 1'b0;
      wait_q  <= 4'h0;
    end else if (!gnt_pin_oe_n[0] && !gnt_pin_n_o[0]) begin
      wait_q  <= (wait_q == lag) ? wait_q : wait_q + 4'h1;
      grant_q <= (wait_q == lag);
    end else begin
      wait_q  <= 4'h0;
      grant_q <= park;
    end
  end
  // request pin 0 carries the grant in external mode
  assign req_pin_n = ext_mode ? {init_req_n[3:1], ~grant_q} : init_req_n;
endmodule
`default_nettype wire

/* testbench/test_bridge_strap_pin_function_select.sv */
// self-checking bench for strap decode and pin muxing
`timescale 1ns/1ps
`default_nettype none
module test_bridge_strap_pin_function_select;
  logic clk, rst_b, ce, mode_strap_first, mode_strap_second, arbiter_select_strap_n, scan_test_mode_n;
  logic bus_power_clock_control, upstream_multifunction_pin_i, upstream_multifunction_pin_o;
  logic upstream_multifunction_pin_oe_n, downstream_multifunction_pin_i, downstream_multifunction_pin_o;
  logic downstream_multifunction_pin_oe_n, up_clock_run_drive, hot_swap_enumeration_drive;
  logic dn_clock_run_drive, dn_lock_drive, upstream_clock_run_n, upstream_lock_n;
  logic downstream_clock_run_n, downstream_lock_n, hot_swap_handle_switch_n;
  logic [3:0] req_pin_n_i, gnt_pin_n_o, gnt_pin_oe_n, ireq_n, lag, s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic core_req, bus_idle, core_grant, bus_parked, scan_enable, scan_indicator_pin_i;
  logic scan_indicator_pin_o, scan_indicator_pin_oe_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, drv, up_lvl, dn_lvl, park;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int n_fail, total_checks, cyc;
  assign s_axi_wstrb = 4'hf;
  assign {up_clock_run_drive, hot_swap_enumeration_drive, dn_clock_run_drive, dn_lock_drive} = {4{drv}};
  // open-drain terminals: low when driven, else the far side's level
  assign upstream_multifunction_pin_i = upstream_multifunction_pin_oe_n ? up_lvl : upstream_multifunction_pin_o;
  assign downstream_multifunction_pin_i = downstream_multifunction_pin_oe_n ? dn_lvl : downstream_multifunction_pin_o;
  assign scan_indicator_pin_i = scan_indicator_pin_oe_n ? 1'b1 : scan_indicator_pin_o;
  bsp_strap_pinmux dut_u (.*);
  bsp_bus_partner part_u (.clk, .rst_b, .ext_mode(arbiter_select_strap_n), .park, .lag,
    .init_req_n(ireq_n), .gnt_pin_n_o, .gnt_pin_oe_n, .req_pin_n(req_pin_n_i));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic close_out();
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic boot(input logic m0, input logic m1, input logic arb, input logic scn);
    rst_b <= 1'b0;
    {mode_strap_first, mode_strap_second, arbiter_select_strap_n, scan_test_mode_n} <= {m0, m1, arb, scn};
    tick(20);
    rst_b <= 1'b1;
    tick(3);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [31:0] m, input logic [1:0] er);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, ed);
    chk(s_axi_rresp, er);
  endtask
  task automatic t_modes();
    logic [1:0] fn;
    for (int k = 0; k < 3; k++) begin
      fn = (k == 2) ? 2'h3 : k[1:0];
      boot(k[1], k[0], 1'b0, 1'b1);
      {up_lvl, dn_lvl, drv} <= 3'h0;
      tick(3);
      chk({upstream_clock_run_n, upstream_lock_n}, {fn != 2'h0, fn != 2'h1});
      chk({downstream_clock_run_n, downstream_lock_n}, {fn != 2'h0, fn != 2'h1});
      chk(hot_swap_handle_switch_n, fn != 2'h3);
      rd(bsp_pkg::BSP_OFS_STATUS, {22'h0, fn, 8'h0}, 32'h300, 2'h0);
      {up_lvl, dn_lvl, drv} <= 3'h7;
      tick(3);
      chk(upstream_multifunction_pin_oe_n, fn == 2'h1);
      chk(downstream_multifunction_pin_oe_n, fn == 2'h3);
      chk(upstream_clock_run_n, fn != 2'h0);
      chk(downstream_lock_n, fn != 2'h1);
      {up_lvl, drv} <= 2'h0;
      mode_strap_second <= ~k[0];
      tick(3);
      chk(bus_power_clock_control, k == 2);
      chk(upstream_lock_n, fn != 2'h1);
      mode_strap_second <= k[0];
      tick(3);
      chk(bus_power_clock_control, 1'b0);
    end
  endtask
  task automatic t_internal();
    logic [3:0] m;
    boot(1'b0, 1'b0, 1'b0, 1'b1);
    rd(bsp_pkg::BSP_OFS_CTRL, 32'h0, 32'hffffffff, 2'h0);
    bus_idle <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      m = ~(4'h1 << i);
      ireq_n <= m;
      tick(4);
      chk(gnt_pin_n_o, m);
    end
    chk(gnt_pin_oe_n, 4'h0);
    wr(bsp_pkg::BSP_OFS_CTRL, 32'h8, 2'h0);
    ireq_n <= 4'h5;
    tick(4);
    chk(gnt_pin_n_o, 4'h7);
    wr(bsp_pkg::BSP_OFS_CTRL, 32'h2, 2'h0);
    tick(4);
    chk(gnt_pin_n_o, 4'hd);
    ireq_n <= 4'hf;
  endtask
  task automatic t_external();
    int n;
    boot(1'b0, 1'b0, 1'b1, 1'b1);
    chk(gnt_pin_oe_n, 4'he);
    rd(bsp_pkg::BSP_OFS_STATUS, 32'h4, 32'h4, 2'h0);
    {lag, core_req, bus_idle} <= {4'h3, 2'h2};
    tick(3);
    chk(gnt_pin_n_o[0], 1'b0);
    for (n = 0; n < 20 && core_grant !== 1'b1; n++) tick(1);
    chk(core_grant, 1'b1);
    chk(bus_parked, 1'b0);
    {core_req, park, bus_idle} <= 3'h3;
    tick(4);
    chk(bus_parked, 1'b1);
    bus_idle <= 1'b0;
    tick(3);
    chk(bus_parked, 1'b0);
    {park, bus_idle} <= 2'h1;
    tick(4);
    chk(bus_parked, 1'b0);
  endtask
  task automatic t_scan();
    boot(1'b0, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 2; i++) begin
      scan_enable <= i[0];
      tick(3);
      chk(scan_indicator_pin_o, i[0]);
    end
    chk(scan_indicator_pin_oe_n, 1'b0);
    ce <= 1'b0;
    scan_enable <= 1'b0;
    tick(3);
    chk(scan_indicator_pin_o, 1'b1);
    ce <= 1'b1;
    boot(1'b0, 1'b0, 1'b0, 1'b1);
    wr(bsp_pkg::BSP_OFS_CTRL, 32'h100, 2'h0);
    tick(2);
    chk(scan_indicator_pin_o, 1'b1);
    wr(bsp_pkg::BSP_OFS_CTRL, 32'h0, 2'h0);
    tick(2);
    chk(scan_indicator_pin_o, 1'b0);
    wr(4'h8, 32'hffffffff, bsp_pkg::BSP_RESP_SLVERR);
    rd(4'h8, 32'h0, 32'hffffffff, bsp_pkg::BSP_RESP_SLVERR);
    wr(bsp_pkg::BSP_OFS_STATUS, 32'hffffffff, 2'h0);
    rd(bsp_pkg::BSP_OFS_CTRL, 32'h0, 32'hffffffff, 2'h0);
    rd(bsp_pkg::BSP_OFS_STATUS, 32'h18, 32'h1f, 2'h0);
  endtask
  initial begin
    {ce, core_req, bus_idle, scan_enable, drv, up_lvl, dn_lvl, park} <= 8'h80;
    {ireq_n, lag} <= 8'hf0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 40'h0;
    t_modes();
    t_internal();
    t_external();
    t_scan();
    close_out();
  end
endmodule
`default_nettype wire
